// ---- pkg/clk_sys_consts.vh ----
// register offsets, source and power-mode codes, reset values and timing counts
`ifndef CLK_SYS_CONSTS_VH
`define CLK_SYS_CONSTS_VH
`define OFS_CLK_SEL      12'h000
`define OFS_LOOP_CTRL    12'h004
`define OFS_TARGET       12'h008
`define OFS_TAP_STATUS   12'h00c
`define OFS_FAULT_FLAG   12'h010
`define OFS_REQ_EN       12'h014
`define OFS_INT_STATUS   12'h018
`define OFS_INT_CLEAR    12'h01c
`define OFS_INT_ENABLE   12'h020
`define OFS_BYPASS       12'h024
`define SRC_LF           3'h0
`define SRC_HF           3'h1
`define SRC_OSC          3'h2
`define SRC_REF          3'h3
`define CAPTURE_PERIODS  2
`define APPLY_PERIODS    1
`define SETTLE_PERIODS   1024
`define RST_CLK_SEL      12'h222
`define RST_TARGET       16'h0100
`define RST_REQ_EN       3'h7
`define TAP_MAX          5'h1f
`define MOD_MAX          5'h1f
`define PM_ACTIVE        2'h0
`define PM_LIGHT         2'h1
`define PM_DEEP          2'h2
`define PM_DEEPEST       2'h3
`endif

// ---- hdl/glitch_free_mux.v ----
// glitch-free clock multiplexer over four sources
`timescale 1ns/100ps
`default_nettype none
module glitch_free_mux
(
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  input  wire [3:0] src_i,
  input  wire [2:0] sel_i,
  output reg        clk_o
);
  reg  [3:0] en_r;
  reg  [3:0] want_r;
  wire       any_en;
  integer    k;
  assign any_en = |en_r;
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      en_r   <= 4'h0;
      want_r <= 4'h0;
      clk_o  <= 1'b0;
    end
    else
    begin
      for (k = 0; k < 4; k = k + 1)
        want_r[k] <= (sel_i[1:0] == k[1:0]);
      // drop old source only while its level is low, then start new
      for (k = 0; k < 4; k = k + 1)
      begin
        if (en_r[k] && !want_r[k] && !src_i[k])
          en_r[k] <= 1'b0;
        else if (!any_en && want_r[k] && !src_i[k])
          en_r[k] <= 1'b1;
      end
      clk_o <= |(en_r & src_i);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fll_dco_clock_system.v ----
// clock system: loop-steered oscillator, clock selectors, faults, apb
//
// Overview of operation
// - compare oscillator over two reference rising edges
// - two periods capture, one period to apply
// - loop off in light or deeper sleep cases
// - loop tracks target via tap and modulation
// - modulation dithers between tap and tap plus one
// - modulation rolls over, never tap up mod down
// - loop locks within 32x32 reference periods
// - selector writes route source, no false faults
// - set crystal fault raises fault interrupt if enabled
// - idle async serial unit drops request in deep sleep
// - deepest sleep forces low current; bypass bit clearable
// - request enable bits mask peripheral clock requests
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "clk_sys_consts.vh"
module fll_dco_clock_system
(
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ref_clk_i,
  input  wire        osc_clk_i,
  input  wire        lf_clk_i,
  input  wire        hf_clk_i,
  input  wire        lf_fault_i,
  input  wire        hf_fault_i,
  input  wire        osc_fault_i,
  input  wire [1:0]  power_mode_i,
  input  wire        loop_off_status_bit_i,
  input  wire        irq_entry_i,
  input  wire [2:0]  periph_req_i,
  input  wire        serial_async_i,
  input  wire        serial_idle_i,
  output reg         main_clk_o,
  output reg         submain_clk_o,
  output reg         aux_clk_o,
  output reg  [4:0]  osc_coarse_tap_o,
  output reg  [4:0]  osc_modulation_o,
  output reg         osc_fault_nmi_o,
  output reg         low_current_o,
  output reg         lf_osc_bypass_o,
  output reg  [2:0]  clk_active_o,
  output reg         irq_o
);
  localparam ST_IDLE    = 4'b0001;
  localparam ST_CAPTURE = 4'b0010;
  localparam ST_APPLY   = 4'b0100;
  localparam ST_WAIT    = 4'b1000;

  reg  [11:0] clock_select_reg_r;
  reg         loop_en_r;
  reg  [15:0] target_r;
  reg  [2:0]  fault_flag_reg_r;
  reg  [2:0]  request_enable_reg_r;
  reg  [3:0]  int_status_r;
  reg  [3:0]  int_enable_r;
  reg         nmi_en_r;
  reg  [3:0]  state_r;
  reg  [15:0] osc_cnt_r;
  reg  [1:0]  ref_periods_r;
  reg  [10:0] settle_cnt_r;
  reg         locked_r;
  reg         sel_write_r;
  reg  [2:0]  ref_sync_r;
  reg  [2:0]  osc_sync_r;
  reg  [2:0]  lf_sync_r;
  reg  [2:0]  hf_sync_r;
  reg  [2:0]  fault_sync0_r;
  reg  [2:0]  fault_sync1_r;
  reg  [2:0]  fault_sync2_r;
  reg  [1:0]  pm_sync0_r;
  reg  [1:0]  pm_sync1_r;
  reg  [1:0]  pm_sync2_r;
  reg         ref_lvl_r;
  reg         osc_lvl_r;
  reg         ref_prev_r;
  reg         osc_prev_r;
  reg  [1:0]  pm_r;
  reg  [2:0]  fault_lvl_r;
  wire        ref_rise;
  wire        osc_rise;
  wire        loop_run;
  wire        osc_feeds_aux_sub;
  wire        wr;
  wire        rd;
  wire [3:0]  src_vec;
  wire        main_mux;
  wire        sub_mux;
  wire        aux_mux;
  wire [2:0]  req_masked;
  wire [2:0]  fault_new;
  wire        lock_evt;
  wire        sel_evt;
  reg  [4:0]  tap_nxt;
  reg  [4:0]  mod_nxt;
  reg  [31:0] rdata_nxt;

  function is_osc;
    input [2:0] sel;
    begin
      is_osc = (sel == `SRC_OSC);
    end
  endfunction

  // three-stage synchronisers; second and third must agree, except for the lf and hf clocks
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ref_sync_r    <= 3'h0;
      osc_sync_r    <= 3'h0;
      lf_sync_r     <= 3'h0;
      hf_sync_r     <= 3'h0;
      fault_sync0_r <= 3'h0;
      fault_sync1_r <= 3'h0;
      fault_sync2_r <= 3'h0;
      pm_sync0_r    <= 2'h0;
      pm_sync1_r    <= 2'h0;
      pm_sync2_r    <= 2'h0;
      ref_lvl_r     <= 1'b0;
      osc_lvl_r     <= 1'b0;
      ref_prev_r    <= 1'b0;
      osc_prev_r    <= 1'b0;
      pm_r          <= 2'h0;
      fault_lvl_r   <= 3'h0;
    end
    else
    begin
      ref_sync_r    <= {ref_sync_r[1:0], ref_clk_i};
      osc_sync_r    <= {osc_sync_r[1:0], osc_clk_i};
      lf_sync_r     <= {lf_sync_r[1:0], lf_clk_i};
      hf_sync_r     <= {hf_sync_r[1:0], hf_clk_i};
      fault_sync0_r <= {osc_fault_i, hf_fault_i, lf_fault_i};
      fault_sync1_r <= fault_sync0_r;
      fault_sync2_r <= fault_sync1_r;
      pm_sync0_r    <= power_mode_i;
      pm_sync1_r    <= pm_sync0_r;
      pm_sync2_r    <= pm_sync1_r;
      if (ref_sync_r[1] == ref_sync_r[2])
        ref_lvl_r <= ref_sync_r[2];
      if (osc_sync_r[1] == osc_sync_r[2])
        osc_lvl_r <= osc_sync_r[2];
      if (pm_sync1_r == pm_sync2_r)
        pm_r <= pm_sync2_r;
      fault_lvl_r <= (fault_sync1_r & fault_sync2_r) |
                     (fault_lvl_r & (fault_sync1_r | fault_sync2_r));
      ref_prev_r <= ref_lvl_r;
      osc_prev_r <= osc_lvl_r;
    end
  end

  assign ref_rise = ref_lvl_r & ~ref_prev_r;
  assign osc_rise = osc_lvl_r & ~osc_prev_r;

  assign osc_feeds_aux_sub = is_osc(clock_select_reg_r[2:0]) |
                             is_osc(clock_select_reg_r[6:4]);
  // loop gating by power mode; interrupt entry re-enables
  assign loop_run = loop_en_r & (irq_entry_i | ~(
                    (pm_r == `PM_LIGHT && !osc_feeds_aux_sub) ||
                    (pm_r >= `PM_DEEP && loop_off_status_bit_i)));

  // tap and modulation correction, modulation wraps into tap
  always @*
  begin
    tap_nxt = osc_coarse_tap_o;
    mod_nxt = osc_modulation_o;
    if (osc_cnt_r < target_r)
    begin
      if (osc_modulation_o == `MOD_MAX)
      begin
        if (osc_coarse_tap_o != `TAP_MAX)
        begin
          tap_nxt = osc_coarse_tap_o + 5'h01;
          mod_nxt = 5'h00;
        end
      end
      else
        mod_nxt = osc_modulation_o + 5'h01;
    end
    else if (osc_cnt_r > target_r)
    begin
      if (osc_modulation_o == 5'h00)
      begin
        if (osc_coarse_tap_o != 5'h00)
        begin
          tap_nxt = osc_coarse_tap_o - 5'h01;
          mod_nxt = `MOD_MAX;
        end
      end
      else
        mod_nxt = osc_modulation_o - 5'h01;
    end
  end

  // capture over two reference periods, then apply in one
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r          <= ST_IDLE;
      osc_cnt_r        <= 16'h0000;
      ref_periods_r    <= 2'h0;
      osc_coarse_tap_o <= 5'h10;
      osc_modulation_o <= 5'h00;
      settle_cnt_r     <= 11'h000;
      locked_r         <= 1'b0;
    end
    else if (!loop_run)
    begin
      // abort partial measurement: no drift from short enables
      state_r       <= ST_IDLE;
      osc_cnt_r     <= 16'h0000;
      ref_periods_r <= 2'h0;
      settle_cnt_r  <= 11'h000;
      locked_r      <= 1'b0;
    end
    else
    begin
      if (ref_rise && settle_cnt_r != `SETTLE_PERIODS)
        settle_cnt_r <= settle_cnt_r + 11'h001;
      if (ref_rise && settle_cnt_r == `SETTLE_PERIODS - 1)
        locked_r <= 1'b1;
      case (state_r)
        ST_IDLE:
        begin
          if (ref_rise)
          begin
            state_r       <= ST_CAPTURE;
            osc_cnt_r     <= 16'h0000;
            ref_periods_r <= 2'h0;
          end
        end
        ST_CAPTURE:
        begin
          if (osc_rise && osc_cnt_r != 16'hffff)
            osc_cnt_r <= osc_cnt_r + 16'h0001;
          if (ref_rise)
          begin
            ref_periods_r <= ref_periods_r + 2'h1;
            if (ref_periods_r == `CAPTURE_PERIODS - 1)
              state_r <= ST_APPLY;
          end
        end
        ST_APPLY:
        begin
          osc_coarse_tap_o <= tap_nxt;
          osc_modulation_o <= mod_nxt;
          state_r          <= ST_WAIT;
          ref_periods_r    <= 2'h0;
        end
        ST_WAIT:
        begin
          if (ref_rise)
          begin
            ref_periods_r <= ref_periods_r + 2'h1;
            if (ref_periods_r == `APPLY_PERIODS - 1)
            begin
              state_r   <= ST_CAPTURE;
              osc_cnt_r <= 16'h0000;
              ref_periods_r <= 2'h0;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  assign src_vec = {ref_lvl_r, osc_lvl_r, hf_sync_r[2], lf_sync_r[2]};

  glitch_free_mux u_main_mux
  (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .src_i     (src_vec),
    .sel_i     (clock_select_reg_r[10:8]),
    .clk_o     (main_mux)
  );

  glitch_free_mux u_sub_mux
  (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .src_i     (src_vec),
    .sel_i     (clock_select_reg_r[6:4]),
    .clk_o     (sub_mux)
  );

  glitch_free_mux u_aux_mux
  (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .src_i     (src_vec),
    .sel_i     (clock_select_reg_r[2:0]),
    .clk_o     (aux_mux)
  );

  // request gating: serial async idle drops submain request in deep sleep
  assign req_masked = periph_req_i & request_enable_reg_r &
                      ~{1'b0, (serial_async_i & serial_idle_i &
                               pm_r >= `PM_DEEP), 1'b0};

  // faults count only for crystals actually selected; no false flag
  assign fault_new = fault_lvl_r & {1'b1,
    (clock_select_reg_r[10:8] == `SRC_HF) |
    (clock_select_reg_r[6:4] == `SRC_HF) |
    (clock_select_reg_r[2:0] == `SRC_HF),
    (clock_select_reg_r[10:8] == `SRC_LF) |
    (clock_select_reg_r[6:4] == `SRC_LF) |
    (clock_select_reg_r[2:0] == `SRC_LF)};

  assign lock_evt = ref_rise & loop_run &
                    (settle_cnt_r == `SETTLE_PERIODS - 1);
  assign sel_evt  = sel_write_r;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;

  always @*
  begin
    rdata_nxt = 32'h00000000;
    case (paddr)
      `OFS_CLK_SEL:    rdata_nxt[11:0] = clock_select_reg_r;
      `OFS_LOOP_CTRL:  rdata_nxt[1:0]  = {locked_r, loop_en_r};
      `OFS_TARGET:     rdata_nxt[15:0] = target_r;
      `OFS_TAP_STATUS: rdata_nxt[12:0] = {loop_run, 2'h0, osc_modulation_o,
                                         osc_coarse_tap_o};
      `OFS_FAULT_FLAG: rdata_nxt[3:0]  = {nmi_en_r, fault_flag_reg_r};
      `OFS_REQ_EN:     rdata_nxt[2:0]  = request_enable_reg_r;
      `OFS_INT_STATUS: rdata_nxt[3:0]  = int_status_r;
      `OFS_INT_ENABLE: rdata_nxt[3:0]  = int_enable_r;
      `OFS_BYPASS:     rdata_nxt[0]    = lf_osc_bypass_o;
      default:         rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clock_select_reg_r   <= `RST_CLK_SEL;
      loop_en_r            <= 1'b1;
      target_r             <= `RST_TARGET;
      fault_flag_reg_r     <= 3'h0;
      request_enable_reg_r <= `RST_REQ_EN;
      int_status_r         <= 4'h0;
      int_enable_r         <= 4'h0;
      nmi_en_r             <= 1'b0;
      sel_write_r          <= 1'b0;
      lf_osc_bypass_o      <= 1'b0;
      prdata               <= 32'h00000000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end
    else
    begin
      pready      <= psel & ~penable;
      pslverr     <= 1'b0;
      sel_write_r <= 1'b0;
      if (psel && !penable)
      begin
        prdata  <= rd ? rdata_nxt : 32'h00000000;
        pslverr <= (paddr > `OFS_BYPASS) | (paddr[1:0] != 2'h0) |
                   (rd && paddr == `OFS_INT_CLEAR);
      end
      if (wr && pready)
      begin
        case (paddr)
          `OFS_CLK_SEL:
          begin
            clock_select_reg_r <= pwdata[11:0];
            sel_write_r        <= 1'b1;
          end
          `OFS_LOOP_CTRL:  loop_en_r            <= pwdata[0];
          `OFS_TARGET:     target_r             <= pwdata[15:0];
          `OFS_REQ_EN:     request_enable_reg_r <= pwdata[2:0];
          `OFS_INT_ENABLE: int_enable_r         <= pwdata[3:0];
          `OFS_BYPASS:     lf_osc_bypass_o      <= pwdata[0];
          `OFS_FAULT_FLAG: nmi_en_r             <= pwdata[3];
          default:         nmi_en_r             <= nmi_en_r;
        endcase
      end
      // set wins over software clear
      fault_flag_reg_r <= (fault_flag_reg_r &
        ~((wr && pready && paddr == `OFS_FAULT_FLAG) ?
          ~pwdata[2:0] : 3'h0)) | fault_new;
      int_status_r <= (int_status_r &
        ~((wr && pready && paddr == `OFS_INT_CLEAR) ?
          pwdata[3:0] : 4'h0)) |
        {sel_evt, lock_evt, |fault_new, 1'b0};
    end
  end

  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      main_clk_o      <= 1'b0;
      submain_clk_o   <= 1'b0;
      aux_clk_o       <= 1'b0;
      osc_fault_nmi_o <= 1'b0;
      low_current_o   <= 1'b0;
      clk_active_o    <= 3'h0;
      irq_o           <= 1'b0;
    end
    else
    begin
      main_clk_o      <= main_mux;
      submain_clk_o   <= sub_mux;
      aux_clk_o       <= aux_mux;
      osc_fault_nmi_o <= nmi_en_r & (|fault_flag_reg_r);
      low_current_o   <= (pm_r == `PM_DEEPEST);
      clk_active_o    <= (pm_r == `PM_ACTIVE) ? 3'h7 : req_masked;
      irq_o           <= |(int_status_r & int_enable_r);
    end
  end
endmodule
`default_nettype wire

// ---- bench/fll_dco_clock_system_checker.sv ----
// concurrent checks on the clock system ports
`timescale 1ns/100ps
`default_nettype none
module fll_dco_clock_system_checker
(
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  power_mode_i,
  input wire logic [4:0]  osc_coarse_tap_o,
  input wire logic [4:0]  osc_modulation_o,
  input wire logic        osc_fault_nmi_o,
  input wire logic        low_current_o,
  input wire logic [2:0]  clk_active_o,
  input wire logic        main_clk_o,
  input wire logic        aux_clk_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire logic xfer;
  assign xfer = psel & penable & pready;
  AST_READY_IN_ACCESS: assert property (
    psel && penable && !$past(penable) |-> pready)
    else $error("no ready in first access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held over two cycles");
  AST_ERR_ONLY_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_REFUSED_ERR: assert property (xfer && (paddr > 12'h024 ||
    paddr[1:0] != 2'h0 || (!pwrite && paddr == 12'h01c)) |-> pslverr)
    else $error("refused access not flagged");
  AST_NO_TAP_UP_MOD_DOWN: assert property (
    osc_coarse_tap_o > $past(osc_coarse_tap_o) &&
    osc_modulation_o < $past(osc_modulation_o)
    |-> $past(osc_modulation_o) == 5'h1f && osc_modulation_o == 5'h00)
    else $error("tap raised while modulation fell");
  AST_TRIM_SPACED: assert property (
    $changed({osc_coarse_tap_o, osc_modulation_o})
    |=> $stable({osc_coarse_tap_o, osc_modulation_o})[*4])
    else $error("trim changed twice in a row");
  AST_DEEPEST_LOW: assert property (
    (power_mode_i == 2'h3)[*8] |-> low_current_o)
    else $error("no low current in deepest sleep");
  AST_AWAKE_NOT_LOW: assert property (
    (power_mode_i != 2'h3)[*8] |-> !low_current_o)
    else $error("low current outside deepest sleep");
  AST_ACTIVE_ALL: assert property (
    (power_mode_i == 2'h0)[*8] |-> clk_active_o == 3'h7)
    else $error("clock missing in active mode");
  AST_NMI_OFF: assert property (
    xfer && pwrite && paddr == 12'h010 && !pwdata[3] |-> ##[1:2]
    !osc_fault_nmi_o)
    else $error("fault interrupt stays while disabled");
  AST_IRQ_MASKED: assert property (
    xfer && pwrite && paddr == 12'h020 && pwdata == 32'h0 |-> ##[1:2] !irq_o)
    else $error("interrupt stays while masked");
  AST_MAIN_NO_GLITCH: assert property ($rose(main_clk_o) |=> main_clk_o)
    else $error("main clock pulse truncated");
  AST_AUX_NO_GLITCH: assert property ($rose(aux_clk_o) |=> aux_clk_o)
    else $error("aux clock pulse truncated");
  cover property (xfer && pslverr);
  cover property ($rose(irq_o));
  cover property ($rose(osc_fault_nmi_o));
  cover property ($rose(low_current_o));
endmodule
bind fll_dco_clock_system fll_dco_clock_system_checker
  fll_dco_clock_system_checker_i (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .power_mode_i(power_mode_i), .osc_coarse_tap_o(osc_coarse_tap_o),
  .osc_modulation_o(osc_modulation_o), .osc_fault_nmi_o(osc_fault_nmi_o),
  .low_current_o(low_current_o), .clk_active_o(clk_active_o),
  .irq_o(irq_o), .main_clk_o(main_clk_o), .aux_clk_o(aux_clk_o));
`default_nettype wire

// ---- bench/clk_partner.sv ----
// behavioural oscillator, reference and crystal sources
`timescale 1ns/100ps
`default_nettype none
module clk_partner
(
  input  wire logic [4:0] tap_i,
  input  wire logic [4:0] mod_i,
  output var  logic       ref_clk_o,
  output var  logic       osc_clk_o,
  output var  logic       lf_clk_o,
  output var  logic       hf_clk_o
);
  initial
  begin
    ref_clk_o = 1'h0;
    forever #200 ref_clk_o = ~ref_clk_o;
  end
  // higher tap is faster, modulation moves toward the next tap
  initial
  begin
    osc_clk_o = 1'h0;
    forever #(51.0 - tap_i - mod_i / 32.0) osc_clk_o = ~osc_clk_o;
  end
  initial
  begin
    lf_clk_o = 1'h0;
    forever #310 lf_clk_o = ~lf_clk_o;
  end
  initial
  begin
    hf_clk_o = 1'h0;
    forever #45 hf_clk_o = ~hf_clk_o;
  end
endmodule
`default_nettype wire

// ---- bench/fll_dco_clock_system_test.sv ----
// self-checking bench for the clock system
`timescale 1ns/100ps
`default_nettype none
`include "clk_sys_consts.vh"
`define chk(g, x) \
  begin \
    n_checks++; \
    if ((g) !== (x)) \
    begin \
      fail_count++; \
      $display("ERROR %0t got %h exp %h", $time, g, x); \
    end \
  end
module fll_dco_clock_system_test;
  typedef struct {
    logic        w;
    logic [11:0] a;
    logic [31:0] d, m, x;
    logic        e;
  } row_t;
  row_t        rows [9];
  logic        sys_clk_i, resetn_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e, ref_clk, osc_clk, lf_clk, hf_clk, loop_off_i, irq_entry_i;
  logic        lf_fault_i, hf_fault_i, osc_fault_i, serial_async_i;
  logic        serial_idle_i, nmi_o, low_current_o, bypass_o, irq_o;
  logic [1:0]  power_mode_i;
  logic [2:0]  periph_req_i, clk_active_o;
  logic [4:0]  tap_o, mod_o;
  logic        main_o, sub_o, aux_o;
  int          fail_count, n_checks;
  int          n_main, n_sub, n_aux;
  fll_dco_clock_system fll_dco_clock_system_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clk_i(ref_clk), .osc_clk_i(osc_clk),
    .lf_clk_i(lf_clk), .hf_clk_i(hf_clk), .lf_fault_i(lf_fault_i),
    .hf_fault_i(hf_fault_i), .osc_fault_i(osc_fault_i),
    .power_mode_i(power_mode_i), .loop_off_status_bit_i(loop_off_i),
    .irq_entry_i(irq_entry_i), .periph_req_i(periph_req_i),
    .serial_async_i(serial_async_i), .serial_idle_i(serial_idle_i),
    .main_clk_o(main_o), .submain_clk_o(sub_o), .aux_clk_o(aux_o),
    .osc_coarse_tap_o(tap_o), .osc_modulation_o(mod_o),
    .osc_fault_nmi_o(nmi_o), .low_current_o(low_current_o),
    .lf_osc_bypass_o(bypass_o), .clk_active_o(clk_active_o), .irq_o(irq_o));
  clk_partner clk_partner_i (.tap_i(tap_o), .mod_i(mod_o),
    .ref_clk_o(ref_clk), .osc_clk_o(osc_clk), .lf_clk_o(lf_clk),
    .hf_clk_o(hf_clk));
  always @(posedge main_o) n_main++;
  always @(posedge sub_o) n_sub++;
  always @(posedge aux_o) n_aux++;
  initial
  begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'h1;
      @(posedge sys_clk_i);
      while (pready !== 1'h1 && n < 16)
      begin
        n++;
        @(posedge sys_clk_i);
      end
      if (n == 16)
      begin
        $display("ERROR %0t no pready", $time);
        fail_count++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sys_clk_i);
    end
  endtask
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    #200000;
    $display("ERROR %0t watchdog expired", $time);
    fail_count++;
    close_out();
  end
  initial
  begin
    rows = '{'{1'h0, `OFS_CLK_SEL, 32'h0, 32'h777, 32'h222, 1'h0},
      '{1'h0, `OFS_LOOP_CTRL, 32'h0, 32'h1, 32'h1, 1'h0},
      '{1'h0, `OFS_TARGET, 32'h0, 32'hffff, 32'h100, 1'h0},
      '{1'h0, `OFS_TAP_STATUS, 32'h0, 32'h3ff, 32'h10, 1'h0},
      '{1'h0, `OFS_REQ_EN, 32'h0, 32'h7, 32'h7, 1'h0},
      '{1'h0, `OFS_FAULT_FLAG, 32'h0, 32'hf, 32'h0, 1'h0},
      '{1'h0, `OFS_INT_CLEAR, 32'h0, 32'h0, 32'h0, 1'h1},
      '{1'h1, 12'h002, 32'h0, 32'h0, 32'h0, 1'h1},
      '{1'h0, 12'h028, 32'h0, 32'h0, 32'h0, 1'h1}};
    fail_count = 0;
    n_checks = 0;
    {resetn_i, psel, penable, pwrite, loop_off_i, irq_entry_i} = 6'h0;
    {lf_fault_i, hf_fault_i, osc_fault_i, serial_async_i} = 4'h0;
    serial_idle_i = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    power_mode_i = `PM_ACTIVE;
    periph_req_i = 3'h7;
    tick(2);
    resetn_i <= 1'h1;
    tick(1);
    for (int i = 0; i < 9; i++)
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      `chk(q & rows[i].m, rows[i].x)
      `chk(e, rows[i].e)
    end
    // aux and sub from the slow crystal, main from the oscillator
    apb(1'h1, `OFS_INT_ENABLE, 32'h8);
    apb(1'h1, `OFS_CLK_SEL, 32'h200);
    apb(1'h0, `OFS_CLK_SEL, 32'h0);
    `chk(q[10:0], 11'h200)
    `chk(irq_o, 1'h1)
    apb(1'h1, `OFS_INT_ENABLE, 32'h0);
    tick(1);
    `chk(irq_o, 1'h0)
    apb(1'h1, `OFS_INT_ENABLE, 32'h8);
    apb(1'h1, `OFS_INT_CLEAR, 32'h8);
    apb(1'h0, `OFS_INT_STATUS, 32'h0);
    `chk(q[3], 1'h0)
    `chk(irq_o, 1'h0)
    apb(1'h1, `OFS_FAULT_FLAG, 32'h0);
    hf_fault_i <= 1'h1;
    tick(8);
    apb(1'h0, `OFS_FAULT_FLAG, 32'h0);
    `chk(q[1], 1'h0)
    lf_fault_i <= 1'h1;
    tick(8);
    {lf_fault_i, hf_fault_i} <= 2'h0;
    tick(8);
    apb(1'h0, `OFS_FAULT_FLAG, 32'h0);
    `chk(q[0], 1'h1)
    `chk(nmi_o, 1'h0)
    apb(1'h1, `OFS_FAULT_FLAG, 32'hf);
    tick(2);
    `chk(nmi_o, 1'h1)
    apb(1'h1, `OFS_FAULT_FLAG, 32'h0);
    tick(2);
    `chk(nmi_o, 1'h0)
    apb(1'h0, `OFS_FAULT_FLAG, 32'h0);
    `chk(q[2:0], 3'h0)
    `chk(clk_active_o, 3'h7)
    apb(1'h1, `OFS_REQ_EN, 32'h6);
    power_mode_i <= `PM_LIGHT;
    tick(8);
    `chk(clk_active_o, 3'h6)
    {serial_async_i, serial_idle_i, periph_req_i} <= 5'h1f;
    power_mode_i <= `PM_DEEP;
    tick(8);
    `chk(clk_active_o, 3'h4)
    power_mode_i <= `PM_DEEPEST;
    tick(8);
    `chk(low_current_o, 1'h1)
    apb(1'h1, `OFS_BYPASS, 32'h1);
    `chk(bypass_o, 1'h1)
    apb(1'h1, `OFS_BYPASS, 32'h0);
    `chk(bypass_o, 1'h0)
    power_mode_i <= `PM_ACTIVE;
    apb(1'h1, `OFS_TARGET, 32'h10);
    tick(4000);
    apb(1'h0, `OFS_TAP_STATUS, 32'h0);
    `chk(q[12], 1'h1)
    `chk({q[4:0], q[9:5]} > 10'h200, 1'h1)
    `chk(n_main > 2 * n_sub && n_aux > 0, 1'h1)
    power_mode_i <= `PM_LIGHT;
    tick(10);
    apb(1'h0, `OFS_TAP_STATUS, 32'h0);
    `chk(q[12], 1'h0)
    irq_entry_i <= 1'h1;
    tick(10);
    apb(1'h0, `OFS_TAP_STATUS, 32'h0);
    `chk(q[12], 1'h1)
    {irq_entry_i, loop_off_i} <= 2'h1;
    power_mode_i <= `PM_DEEP;
    tick(10);
    apb(1'h0, `OFS_TAP_STATUS, 32'h0);
    `chk(q[12], 1'h0)
    power_mode_i <= `PM_ACTIVE;
    resetn_i <= 1'h0;
    tick(2);
    resetn_i <= 1'h1;
    tick(1);
    `chk(tap_o, 5'h10)
    apb(1'h0, `OFS_CLK_SEL, 32'h0);
    `chk(q[10:0], 11'h222)
    close_out();
  end
endmodule
`default_nettype wire
